// file: src/dmaecg_gate.sv
// DMA channel-controller event gating, null-set error flags and completion interrupts.
// Assumes all inputs except rst_b are synchronous to clk_sys; software actions arrive as one-cycle
// pulses or write-one masks, and transfer completions as a strobe with a code.
//
// What this block does
// - Latched peripheral events are serviced only when their enable bit is set.
// - Queued-channel triggers are prioritized only when their queued enable bit is set.
// - A set secondary-event flag blocks further service of that channel.
// - Non-static set with link 0xFFFF becomes null after its last request.
// - Updating a queued channel's set, null reload included, triggers that channel.
// - Queued trigger on a null set sets queued missed and secondary flags.
// - Peripheral event on a null set sets secondary and missed flags.
// - Completion interrupt only for pending bits whose enable bit is set.
// - Region interrupt needs enable bit and region access bit both set.
// - Pending bit is chosen by completion code; code 63 sets upper bit 63.
// - Completion code is six bits and selects chained or pending bit.
// - Latch cleared by clear port or when its event is serviced; enables changed only by set/clear ports.
// - Overlapping region masks raise each matching region's interrupt.
// - Pending bits clear by writing one to the completion clear port.
`timescale 1ns/1ps
module dmaecg_gate
    import dmaecg_pkg::*;
#(
    parameter int NCH  = dmaecg_pkg::DMAECG_NUM_CH,
    parameter int NQCH = dmaecg_pkg::DMAECG_NUM_QCH,
    parameter int NREG = dmaecg_pkg::DMAECG_NUM_REGION
)(
    input  wire logic                                 clk_sys,
    input  wire logic                                 rst_b,
    input  wire logic [NCH-1:0]                       periph_event,
    input  wire logic [NCH-1:0]                       event_set_port,
    input  wire logic [NCH-1:0]                       event_clear_port,
    input  wire logic [NCH-1:0]                       event_enable_set_port,
    input  wire logic [NCH-1:0]                       event_enable_clear_port,
    input  wire logic [NCH-1:0]                       secondary_clear_port,
    input  wire logic [NCH-1:0]                       missed_clear_port,
    input  wire logic [NQCH-1:0]                      queued_enable_set_port,
    input  wire logic [NQCH-1:0]                      queued_enable_clear_port,
    input  wire logic [NQCH-1:0]                      queued_secondary_clear_port,
    input  wire logic [NQCH-1:0]                      queued_missed_clear_port,
    input  wire logic                                 set_write,
    input  wire logic                                 set_write_queued,
    input  wire logic [dmaecg_pkg::DMAECG_CH_W-1:0]   set_write_ch,
    input  wire logic                                 set_write_null,
    input  wire logic                                 request_done,
    input  wire logic                                 request_done_queued,
    input  wire logic [dmaecg_pkg::DMAECG_CH_W-1:0]   request_done_ch,
    input  wire logic                                 request_done_last,
    input  wire logic                                 request_done_static,
    input  wire logic [dmaecg_pkg::DMAECG_LINK_W-1:0] request_done_link,
    input  wire logic                                 service_ready,
    input  wire logic                                 completion_valid,
    input  wire logic [dmaecg_pkg::DMAECG_CODE_W-1:0] completion_code,
    input  wire logic                                 completion_chain,
    input  wire logic [NCH-1:0]                       completion_irq_enable_set_port,
    input  wire logic [NCH-1:0]                       completion_irq_enable_clear_port,
    input  wire logic [NCH-1:0]                       completion_clear_port,
    input  wire logic [NCH-1:0]                       chained_clear_port,
    input  wire logic [NREG*NCH-1:0]                  region_access_mask,
    output logic                                      service_valid,
    output logic                                      service_queued,
    output logic [dmaecg_pkg::DMAECG_CH_W-1:0]        service_ch,
    output logic [NCH-1:0]                            event_latch,
    output logic [NCH-1:0]                            event_enable_mask,
    output logic [NCH-1:0]                            secondary_event_flags,
    output logic [NCH-1:0]                            missed_event_flags,
    output logic [NCH-1:0]                            null_set_flags,
    output logic [NQCH-1:0]                           queued_event_enable_mask,
    output logic [NQCH-1:0]                           queued_secondary_event_flags,
    output logic [NQCH-1:0]                           queued_missed_event_flags,
    output logic [NQCH-1:0]                           queued_null_set_flags,
    output logic [NQCH-1:0]                           queued_trigger_pending,
    output logic [NCH-1:0]                            chained_event_flags,
    output logic [NCH-1:0]                            completion_irq_enable,
    output logic [NCH-1:0]                            completion_pending,
    output logic                                      completion_irq,
    output logic [NREG-1:0]                           region_irq
);
    import dmaecg_pkg::*;

    logic rst_s1_reg;
    logic rst_s2_reg;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire logic rst_n = rst_s2_reg;

    // One-hot decodes of channel indices; out-of-range queued indices decode to nothing.
    wire logic [NCH-1:0]  wr_onehot   = NCH'(1) << set_write_ch;
    wire logic [NCH-1:0]  done_onehot = NCH'(1) << request_done_ch;
    wire logic [NCH-1:0]  code_onehot = NCH'(1) << completion_code;
    wire logic [NQCH-1:0] qwr_onehot  = NQCH'(1) << set_write_ch;
    wire logic [NQCH-1:0] qdone_onehot = NQCH'(1) << request_done_ch;

    wire logic dma_wr  = set_write && !set_write_queued;
    wire logic queued_channel_wr = set_write && set_write_queued;
    // A last request on a non-static set with the null link makes the set null.
    wire logic done_null = request_done && request_done_last && !request_done_static
                           && (request_done_link == DMAECG_LINK_NULL);

    wire logic [NCH-1:0] null_set_s = (dma_wr && set_write_null) ? wr_onehot : '0;
    wire logic [NCH-1:0] null_set_r = (dma_wr && !set_write_null) ? wr_onehot : '0;
    wire logic [NCH-1:0] null_by_done =
        (done_null && !request_done_queued) ? done_onehot : '0;
    wire logic [NQCH-1:0] qnull_s = (queued_channel_wr && set_write_null) ? qwr_onehot : '0;
    wire logic [NQCH-1:0] qnull_r = (queued_channel_wr && !set_write_null) ? qwr_onehot : '0;
    wire logic [NQCH-1:0] qnull_by_done =
        (done_null && request_done_queued) ? qdone_onehot : '0;

    // A queued set update, including the null reload, is itself a trigger.
    wire logic [NQCH-1:0] qtrig = (queued_channel_wr ? qwr_onehot : '0) | qnull_by_done;
    wire logic [NQCH-1:0] qnull_now = queued_null_set_flags | qnull_by_done | qnull_s;
    wire logic [NQCH-1:0] qtrig_en  = qtrig & queued_event_enable_mask;
    wire logic [NQCH-1:0] qerr      = qtrig_en & qnull_now & ~qnull_r;

    // Incoming peripheral events that hit an enabled channel on a null set are errors.
    wire logic [NCH-1:0] ev_in  = periph_event | event_set_port;
    wire logic [NCH-1:0] ev_err = ev_in & event_enable_mask & null_set_flags;

    // Eligible work: enabled, not blocked by a secondary flag, and for DMA channels set not null.
    wire logic [NCH-1:0]  dma_elig  = event_latch & event_enable_mask & ~null_set_flags
                                      & ~secondary_event_flags;
    wire logic [NQCH-1:0] queued_channel_elig = queued_trigger_pending & queued_event_enable_mask
                                      & ~queued_secondary_event_flags;

    // Fixed priority: queued channels first, lowest index wins; the trade is simplicity
    // over fairness, so a busy low channel can starve higher ones.
    logic                  pick_valid;
    logic                  pick_q;
    logic [DMAECG_CH_W-1:0] pick_ch;
    always_comb
    begin
        pick_valid = 1'b0;
        pick_q     = 1'b0;
        pick_ch    = '0;
        for (int i = NCH - 1; i >= 0; i--)
        begin
            if (dma_elig[i])
            begin
                pick_valid = 1'b1;
                pick_ch    = DMAECG_CH_W'(i);
            end
        end
        for (int j = NQCH - 1; j >= 0; j--)
        begin
            if (queued_channel_elig[j])
            begin
                pick_valid = 1'b1;
                pick_q     = 1'b1;
                pick_ch    = DMAECG_CH_W'(j);
            end
        end
    end
    assign service_valid  = pick_valid;
    assign service_queued = pick_q;
    assign service_ch     = pick_ch;
    wire logic take = pick_valid && service_ready;
    wire logic [NCH-1:0]  take_dma  = (take && !pick_q) ? (NCH'(1) << pick_ch) : '0;
    wire logic [NQCH-1:0] take_queued_channel = (take && pick_q) ? (NQCH'(1) << pick_ch) : '0;

    // Completion: code picks the bit, the chain option picks the register.
    wire logic [NCH-1:0] cpl_pend  = (completion_valid && !completion_chain) ? code_onehot : '0;
    wire logic [NCH-1:0] cpl_chain = (completion_valid && completion_chain) ? code_onehot : '0;

    // Sets win over clears on every flag that software clears.
    wire logic [NCH-1:0] latch_next   = (event_latch & ~event_clear_port & ~take_dma)
                                        | (ev_in & ~ev_err);
    wire logic [NCH-1:0] enable_next  = (event_enable_mask & ~event_enable_clear_port)
                                        | event_enable_set_port;
    wire logic [NCH-1:0] sec_next     = (secondary_event_flags & ~secondary_clear_port)
                                        | ev_err;
    wire logic [NCH-1:0] miss_next    = (missed_event_flags & ~missed_clear_port) | ev_err;
    wire logic [NCH-1:0] null_next    = (null_set_flags & ~null_set_r) | null_set_s | null_by_done;
    wire logic [NQCH-1:0] qen_next    = (queued_event_enable_mask & ~queued_enable_clear_port)
                                        | queued_enable_set_port;
    wire logic [NQCH-1:0] qsec_next   = (queued_secondary_event_flags
                                        & ~queued_secondary_clear_port) | qerr;
    wire logic [NQCH-1:0] qmiss_next  = (queued_missed_event_flags & ~queued_missed_clear_port)
                                        | qerr;
    wire logic [NQCH-1:0] qnull_next  = (queued_null_set_flags & ~qnull_r) | qnull_s
                                        | qnull_by_done;
    wire logic [NQCH-1:0] qtrig_next  = (queued_trigger_pending & ~take_queued_channel) | (qtrig_en & ~qerr);
    wire logic [NCH-1:0] ier_next     = (completion_irq_enable & ~completion_irq_enable_clear_port)
                                        | completion_irq_enable_set_port;
    wire logic [NCH-1:0] pend_next    = (completion_pending & ~completion_clear_port)
                                        | cpl_pend;
    wire logic [NCH-1:0] chain_next   = (chained_event_flags & ~chained_clear_port) | cpl_chain;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            event_latch                  <= DMAECG_RST_MASK64;
            event_enable_mask            <= DMAECG_RST_MASK64;
            secondary_event_flags        <= DMAECG_RST_MASK64;
            missed_event_flags           <= DMAECG_RST_MASK64;
            null_set_flags               <= DMAECG_RST_MASK64;
            queued_event_enable_mask     <= DMAECG_RST_MASK8;
            queued_secondary_event_flags <= DMAECG_RST_MASK8;
            queued_missed_event_flags    <= DMAECG_RST_MASK8;
            queued_null_set_flags        <= DMAECG_RST_MASK8;
            queued_trigger_pending       <= DMAECG_RST_MASK8;
            completion_irq_enable        <= DMAECG_RST_MASK64;
            completion_pending           <= DMAECG_RST_MASK64;
            chained_event_flags          <= DMAECG_RST_MASK64;
        end
        else
        begin
            event_latch                  <= latch_next;
            event_enable_mask            <= enable_next;
            secondary_event_flags        <= sec_next;
            missed_event_flags           <= miss_next;
            null_set_flags               <= null_next;
            queued_event_enable_mask     <= qen_next;
            queued_secondary_event_flags <= qsec_next;
            queued_missed_event_flags    <= qmiss_next;
            queued_null_set_flags        <= qnull_next;
            queued_trigger_pending       <= qtrig_next;
            completion_irq_enable        <= ier_next;
            completion_pending           <= pend_next;
            chained_event_flags          <= chain_next;
        end
    end

    // Interrupts are levels from the pending state; the handler must clear the bits.
    wire logic [NCH-1:0]  pend_en        = completion_pending & completion_irq_enable;
    wire logic [NCH-1:0]  pend_en_next_w = pend_next & ier_next;
    wire logic [NREG-1:0] region_next;

    genvar r;
    generate
        for (r = 0; r < NREG; r++)
        begin : g_region
            wire logic [NCH-1:0] region_hit = pend_en_next_w & region_access_mask[r*NCH +: NCH];
            assign region_next[r] = |region_hit;
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            completion_irq <= 1'b0;
            region_irq     <= '0;
        end
        else
        begin
            completion_irq <= |pend_en_next_w;
            region_irq     <= region_next;
        end
    end

    AST_LATCH_GATED: assert property (@(posedge clk_sys) disable iff (!rst_n)
        service_valid && !service_queued |-> event_enable_mask[service_ch]
        && event_latch[service_ch]) else $error("Disabled event was offered.");
    AST_QGATED: assert property (@(posedge clk_sys) disable iff (!rst_n)
        service_valid && service_queued |-> queued_event_enable_mask[service_ch[DMAECG_QCH_W-1:0]])
        else $error("Disabled queued trigger was offered.");
    AST_SEC_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        service_valid && !service_queued |-> !secondary_event_flags[service_ch])
        else $error("Blocked channel was offered.");
    AST_NULL_LINK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        done_null && !request_done_queued && !set_write |=> null_set_flags[$past(request_done_ch)])
        else $error("Null link did not null the set.");
    sequence s_qerr;
        queued_channel_wr && set_write_null && queued_event_enable_mask[set_write_ch[DMAECG_QCH_W-1:0]]
        && set_write_ch < DMAECG_CH_W'(NQCH);
    endsequence
    AST_QNULL_ERR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_qerr |=> queued_missed_event_flags[$past(set_write_ch[DMAECG_QCH_W-1:0])]
        && queued_secondary_event_flags[$past(set_write_ch[DMAECG_QCH_W-1:0])])
        else $error("Queued null trigger not flagged.");
    AST_NULL_ERR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        |ev_err |=> ((secondary_event_flags & missed_event_flags & $past(ev_err))
        == $past(ev_err)))
        else $error("Null event not flagged.");
    AST_CODE_SEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        completion_valid && !completion_chain |=> completion_pending[$past(completion_code)])
        else $error("Code bit not pending.");
    AST_IRQ_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        completion_irq == |pend_en) else $error("Global interrupt wrong.");
    AST_REGION: assert property (@(posedge clk_sys) disable iff (!rst_n)
        region_irq[0] |-> |(pend_en & region_access_mask[NCH-1:0]))
        else $error("Region interrupt without access bit.");
endmodule

// file: src/dmaecg_pkg.sv
// Package for the DMA event and completion gating block.
// Assumes a single system clock; holds widths, reset values and codes.
package dmaecg_pkg;
    localparam int          DMAECG_NUM_CH      = 64;
    localparam int          DMAECG_NUM_QCH     = 8;
    localparam int          DMAECG_NUM_REGION  = 8;
    localparam int          DMAECG_CODE_W      = 6;
    localparam int          DMAECG_CH_W        = 6;
    localparam int          DMAECG_QCH_W       = 3;
    localparam int          DMAECG_LINK_W      = 16;
    localparam logic [15:0] DMAECG_LINK_NULL   = 16'hFFFF;
    localparam logic [63:0] DMAECG_RST_MASK64  = 64'h0000_0000_0000_0000;
    localparam logic [7:0]  DMAECG_RST_MASK8   = 8'h00;
endpackage

// file: tb/dmaecg_tc_model.sv
// Behavioural transfer controller that returns one completion code per request.
// Assumes bench requests arrive as one-cycle pulses synchronous to clk_sys.
`timescale 1ns/1ps
module dmaecg_tc_model
    import dmaecg_pkg::*;
(
    input  wire logic                                 clk_sys,
    input  wire logic                                 rst_b,
    input  wire logic                                 req,
    input  wire logic [dmaecg_pkg::DMAECG_CODE_W-1:0] req_code,
    input  wire logic                                 req_chain,
    input  wire logic [3:0]                           req_delay,
    output logic                                      completion_valid,
    output logic [dmaecg_pkg::DMAECG_CODE_W-1:0]      completion_code,
    output logic                                      completion_chain
);
    logic [4:0]                        cnt_reg;
    logic [DMAECG_CODE_W-1:0]          code_reg;
    logic                              chain_reg;
    // Outside the strobe the lines carry the inverse, so late sampling is caught.
    assign completion_code  = completion_valid ? code_reg : ~code_reg;
    assign completion_chain = completion_valid ? chain_reg : ~chain_reg;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {cnt_reg, code_reg, chain_reg, completion_valid} <= '0;
        end
        else
        begin
            completion_valid <= (cnt_reg == 5'h01);
            if (req)
                {cnt_reg, code_reg, chain_reg} <= {{1'b0, req_delay} + 5'h01, req_code, req_chain};
            else if (cnt_reg != 5'h00)
                cnt_reg <= cnt_reg - 5'h01;
        end
    end
endmodule

// file: tb/tb.sv
// Self-checking bench for the DMA event gating and completion interrupt block.
// Assumes the transfer controller model supplies every completion strobe.
`timescale 1ns/1ps
module tb;
    import dmaecg_pkg::*;
    typedef struct { int sel; logic [63:0] e; } dmaecg_note_t;
    logic clk_sys, rst_b, set_write, set_write_queued, set_write_null, service_ready;
    logic request_done, request_done_queued, request_done_last, request_done_static;
    logic completion_valid, completion_chain, tc_req, tc_chain, en, service_valid;
    logic service_queued, completion_irq;
    logic [63:0] periph_event, event_set_port, event_clear_port, event_enable_set_port;
    logic [63:0] event_enable_clear_port, secondary_clear_port, missed_clear_port;
    logic [63:0] completion_irq_enable_set_port, completion_irq_enable_clear_port;
    logic [63:0] completion_clear_port, chained_clear_port, seen, event_latch;
    logic [63:0] event_enable_mask, secondary_event_flags, missed_event_flags;
    logic [63:0] null_set_flags, chained_event_flags, completion_irq_enable, completion_pending;
    logic [7:0] queued_enable_set_port, queued_enable_clear_port, queued_secondary_clear_port;
    logic [7:0] queued_missed_clear_port, queued_event_enable_mask, queued_secondary_event_flags;
    logic [7:0] queued_missed_event_flags, queued_null_set_flags, queued_trigger_pending;
    logic [7:0] region_irq, rm;
    logic [5:0] set_write_ch, request_done_ch, completion_code, service_ch, tc_code, code;
    logic [15:0] request_done_link;
    logic [511:0] region_access_mask;
    logic [3:0] tc_delay;
    dmaecg_note_t notes[$];
    dmaecg_note_t cur;
    int checks, miscompares;
    event obs_ev;
    dmaecg_gate u_dmaecg_gate (.clk_sys, .rst_b, .periph_event, .event_set_port,
        .event_clear_port, .event_enable_set_port, .event_enable_clear_port,
        .secondary_clear_port, .missed_clear_port, .queued_enable_set_port,
        .queued_enable_clear_port, .queued_secondary_clear_port, .queued_missed_clear_port,
        .set_write, .set_write_queued, .set_write_ch, .set_write_null, .request_done,
        .request_done_queued, .request_done_ch, .request_done_last, .request_done_static,
        .request_done_link, .service_ready, .completion_valid, .completion_code,
        .completion_chain, .completion_irq_enable_set_port, .completion_irq_enable_clear_port,
        .completion_clear_port, .chained_clear_port, .region_access_mask, .service_valid,
        .service_queued, .service_ch, .event_latch, .event_enable_mask, .secondary_event_flags,
        .missed_event_flags, .null_set_flags, .queued_event_enable_mask,
        .queued_secondary_event_flags, .queued_missed_event_flags, .queued_null_set_flags,
        .queued_trigger_pending, .chained_event_flags, .completion_irq_enable,
        .completion_pending, .completion_irq, .region_irq);
    dmaecg_tc_model u_dmaecg_tc_model (.clk_sys, .rst_b, .req(tc_req), .req_code(tc_code),
        .req_chain(tc_chain), .req_delay(tc_delay), .completion_valid, .completion_code,
        .completion_chain);
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task check(input logic [63:0] s, input logic [63:0] e);
        checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task note(input int sel, input logic [63:0] e);
        notes.push_back('{sel, e});
        -> obs_ev;
    endtask
    // One pulse per call; every strobe drops together at the next edge.
    task pls(input int p, input logic [63:0] m);
        @(posedge clk_sys);
        case (p)
            0: periph_event <= m;
            1: event_clear_port <= m;
            2: event_enable_set_port <= m;
            3: secondary_clear_port <= m;
            4: missed_clear_port <= m;
            5: queued_enable_set_port <= m[7:0];
            6: service_ready <= m[0];
            7: completion_irq_enable_set_port <= m;
            8: completion_irq_enable_clear_port <= m;
            9: completion_clear_port <= m;
            10: chained_clear_port <= m;
            11: event_enable_clear_port <= m;
            12: {set_write, set_write_queued, set_write_null, set_write_ch} <= {1'b1, m[7:0]};
            13: {request_done, request_done_queued, request_done_static, request_done_last,
                 request_done_ch, request_done_link} <= {1'b1, m[7:6], 1'b1, m[5:0],
                                                         DMAECG_LINK_NULL};
            14: queued_secondary_clear_port <= m[7:0];
            15: queued_missed_clear_port <= m[7:0];
            17: queued_enable_clear_port <= m[7:0];
            default: event_set_port <= m;
        endcase
        @(posedge clk_sys);
        {periph_event, event_clear_port, event_enable_set_port, secondary_clear_port,
         missed_clear_port, queued_enable_set_port, service_ready, set_write,
         completion_irq_enable_set_port, completion_irq_enable_clear_port, request_done,
         completion_clear_port, chained_clear_port, event_enable_clear_port, event_set_port,
         queued_secondary_clear_port, queued_missed_clear_port, queued_enable_clear_port,
         request_done_link} <= '0;
        #1;
    endtask
    task end_sim();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(obs_ev)
    begin
        while (notes.size() > 0)
        begin
            cur = notes.pop_front();
            case (cur.sel)
                0: seen = event_latch;
                1: seen = 64'({service_valid, service_queued, service_ch});
                2: seen = secondary_event_flags;
                3: seen = missed_event_flags;
                4: seen = null_set_flags;
                5: seen = 64'({queued_missed_event_flags, queued_secondary_event_flags});
                6: seen = completion_pending;
                7: seen = 64'({region_irq, completion_irq});
                8: seen = chained_event_flags;
                10: seen = 64'({queued_null_set_flags, queued_trigger_pending,
                               queued_event_enable_mask});
                11: seen = completion_irq_enable;
                default: seen = event_enable_mask;
            endcase
            check(seen, cur.e);
        end
    end
    initial
    begin
        #75000;
        miscompares++;
        end_sim();
    end
    initial
    begin
        {rst_b, periph_event, event_set_port, event_clear_port, event_enable_set_port,
         event_enable_clear_port, secondary_clear_port, missed_clear_port, set_write,
         queued_enable_set_port, queued_enable_clear_port, queued_secondary_clear_port,
         queued_missed_clear_port, set_write_queued, set_write_ch, set_write_null,
         request_done, request_done_queued, request_done_ch, request_done_last,
         request_done_static, request_done_link, service_ready, region_access_mask,
         completion_irq_enable_set_port, completion_irq_enable_clear_port, tc_req, tc_code,
         completion_clear_port, chained_clear_port, tc_chain, tc_delay} = '0;
        void'($urandom(5070));
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        pls(0, 64'h1 << 5);
        note(0, 64'h1 << 5);
        note(1, 64'h0);
        pls(2, 64'h1 << 5);
        note(9, 64'h1 << 5);
        note(1, 64'h85);
        pls(1, 64'h1 << 5);
        note(0, 64'h0);
        pls(11, 64'h1 << 5);
        note(9, 64'h0);
        pls(2, 64'h1 << 9);
        pls(12, 64'h09);
        pls(13, 64'h09);
        note(4, 64'h1 << 9);
        pls(0, 64'h1 << 9);
        note(2, 64'h1 << 9);
        note(3, 64'h1 << 9);
        note(1, 64'h0);
        pls(12, 64'h09);
        pls(0, 64'h1 << 9);
        note(1, 64'h0);
        pls(3, 64'h1 << 9);
        pls(4, 64'h1 << 9);
        note(2, 64'h0);
        pls(16, 64'h1 << 9);
        note(1, 64'h89);
        pls(6, 64'h1);
        note(0, 64'h0);
        pls(13, 64'h49);
        note(4, 64'h0);
        pls(12, 64'h49);
        note(4, 64'h1 << 9);
        pls(12, 64'h09);
        pls(12, 64'h82);
        note(1, 64'h0);
        pls(5, 64'h04);
        pls(12, 64'h82);
        note(1, 64'hc2);
        note(10, 64'h0404);
        pls(6, 64'h1);
        pls(13, 64'h82);
        repeat (3) @(posedge clk_sys);
        #1;
        note(5, 64'h0404);
        note(1, 64'h0);
        note(10, 64'h4_0004);
        pls(14, 64'h04);
        pls(15, 64'h04);
        note(5, 64'h0);
        pls(12, 64'hc2);
        note(5, 64'h0404);
        pls(17, 64'h04);
        note(10, 64'h4_0000);
        for (int i = 0; i < 6; i++)
        begin
            code = (i == 0) ? 6'h3f : (i == 1) ? 6'h00 : 6'($urandom);
            rm = 8'($urandom) | 8'h03;
            en = (i != 3);
            @(posedge clk_sys);
            for (int r = 0; r < 8; r++) region_access_mask[r * 64 + code] <= rm[r];
            pls(7, en ? (64'h1 << code) : 64'h0);
            note(11, en ? (64'h1 << code) : 64'h0);
            @(posedge clk_sys) {tc_req, tc_code, tc_chain, tc_delay} <= {1'b1, code, i == 5,
                                                                         4'($urandom)};
            @(posedge clk_sys) tc_req <= 1'b0;
            for (int k = 0; k < 40 && completion_valid !== 1'b1; k++) @(posedge clk_sys) #1;
            check(completion_valid, 64'h1);
            @(posedge clk_sys) #1;
            note(8, (i == 5) ? (64'h1 << code) : 64'h0);
            note(6, (i == 5) ? 64'h0 : (64'h1 << code));
            note(7, {(en && i != 5) ? rm : 8'h00, en && i != 5});
            repeat (3) @(posedge clk_sys);
            #1;
            note(7, {(en && i != 5) ? rm : 8'h00, en && i != 5});
            pls(9, '1);
            pls(10, '1);
            pls(8, '1);
            region_access_mask <= '0;
            note(6, 64'h0);
            note(7, 64'h0);
            note(8, 64'h0);
            note(11, 64'h0);
        end
        @(posedge clk_sys);
        end_sim();
    end
endmodule
